// File: pkg/pcs_rx_lane_status_map.svh
`ifndef PCS_RX_LANE_STATUS_MAP_SVH
`define PCS_RX_LANE_STATUS_MAP_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define LANE_COUNT      4
`define SPACING_W       16
`define LOOP_SEL_W      12

// ----------------------------------------
// Values
// ----------------------------------------
`define MAP_RESET       2'h0
`define PCS_LANE_2      2'h2
`define PCS_LANE_3      2'h3
`define REPEAT_LIMIT    2'h3
`define REPEAT_ZERO     2'h0
`define REPEAT_ONE      2'h1
`define COUNT_ZERO      16'h0000
`define COUNT_ONE       16'h0001
`define LANES_CLEAR     4'h0
`define LANES_ALL       4'hF
`define LOOP_SEL_RESET  12'h000

`endif

// File: pkg/pcs_rx_lane_status_pkg.sv
`default_nettype none
`include "pcs_rx_lane_status_map.svh"

package pcs_rx_lane_status_pkg;

  typedef logic [1:0] lane_index_t;
  typedef logic [`SPACING_W-1:0] spacing_t;

  // One received 66-bit word as seen by the status logic
  typedef struct packed {
    logic        valid;
    logic        marker;
    logic        marker_bad;
    lane_index_t pcs_id;
    logic        bip_mismatch;
  } lane_word_t;

  typedef lane_word_t [`LANE_COUNT-1:0] lane_words_t;

endpackage

`default_nettype wire

// File: verilog/pcs_rx_lane_status.sv
// What this block does
// - Report physical lane index carrying PCS lanes 2 and 3 as two-bit fields.
// - Pulse a per-lane error for one cycle on BIP8 signature mismatch.
// - Lock vector bit high only with word lock and a received lane marker.
// - Lock vector carries same meaning as the standard lane lock status bits.
// - Sync fault bit high on lost word lock or marker never received.
// - Pulse spacing fault when markers are not separated by exactly spacing-minus-one non-marker words.
// - Pulse repeat fault when four marker errors follow consecutively on a lane.
// - Pulse one shared format fault when a malformed marker arrives anywhere.
`timescale 1ns/1ns
`default_nettype none
`include "pcs_rx_lane_status_map.svh"

module pcs_rx_lane_status
  import pcs_rx_lane_status_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  // Lane front end
  input  wire lane_words_t             lane_words_in,
  input  wire logic [`LANE_COUNT-1:0]  block_lock_in,
  // Configuration
  input  wire spacing_t                marker_spacing_minus_one_in,
  input  wire logic [`LOOP_SEL_W-1:0]  transceiver_loop_sel_in,
  // Lane mapping
  output var  lane_index_t             lane2_phys_map_out,
  output var  lane_index_t             lane3_phys_map_out,
  // Lane status
  output var  logic [`LANE_COUNT-1:0]  bip_fault_out,
  output var  logic [`LANE_COUNT-1:0]  marker_lock_vec_out,
  output var  logic [`LANE_COUNT-1:0]  sync_fault_out,
  output var  logic [`LANE_COUNT-1:0]  marker_spacing_fault_out,
  output var  logic [`LANE_COUNT-1:0]  marker_repeat_fault_out,
  output var  logic                    marker_format_fault_out,
  // Transceiver control
  output var  logic [`LOOP_SEL_W-1:0]  transceiver_loop_sel_out
);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic spacing_miss(lane_word_t w, logic seen, spacing_t cnt, spacing_t lim);
    spacing_miss = w.valid & w.marker & seen & (cnt != lim);
  endfunction

  function automatic logic good_marker(lane_word_t w);
    good_marker = w.valid & w.marker & ~w.marker_bad;
  endfunction

  // ----------------------------------------
  // Per-lane tracking state, plus the first loopback select stage
  // ----------------------------------------
  logic        [`LANE_COUNT-1:0] seen_q;
  spacing_t    [`LANE_COUNT-1:0] word_cnt_q;
  logic [`LANE_COUNT-1:0][1:0]   repeat_cnt_q;
  logic [`LOOP_SEL_W-1:0]        loop_meta_q;

  // Words since last marker; cleared while lock is absent
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      seen_q     <= `LANES_CLEAR;
      word_cnt_q <= '0;
    end else begin
      for (int i = 0; i < `LANE_COUNT; i++) begin
        if (!block_lock_in[i]) begin
          seen_q[i]     <= 1'b0;
          word_cnt_q[i] <= `COUNT_ZERO;
        end else if (lane_words_in[i].valid) begin
          if (lane_words_in[i].marker) begin
            word_cnt_q[i] <= `COUNT_ZERO;
            if (!lane_words_in[i].marker_bad) begin
              seen_q[i] <= 1'b1;
            end
          end else begin
            word_cnt_q[i] <= word_cnt_q[i] + `COUNT_ONE;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Lock and sync status
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      marker_lock_vec_out <= `LANES_CLEAR;
      sync_fault_out      <= `LANES_ALL;
    end else begin
      marker_lock_vec_out <= block_lock_in & seen_q;
      sync_fault_out      <= ~(block_lock_in & seen_q);
    end
  end

  // ----------------------------------------
  // Lane mapping
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lane2_phys_map_out <= `MAP_RESET;
      lane3_phys_map_out <= `MAP_RESET;
    end else begin
      for (int i = 0; i < `LANE_COUNT; i++) begin
        if (block_lock_in[i] && good_marker(lane_words_in[i])) begin
          if (lane_words_in[i].pcs_id == `PCS_LANE_2) begin
            lane2_phys_map_out <= lane_index_t'(i);
          end
          if (lane_words_in[i].pcs_id == `PCS_LANE_3) begin
            lane3_phys_map_out <= lane_index_t'(i);
          end
        end
      end
    end
  end

  // ----------------------------------------
  // BIP8 faults, indexed by PCS lane
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bip_fault_out <= `LANES_CLEAR;
    end else begin
      bip_fault_out <= `LANES_CLEAR;
      for (int i = 0; i < `LANE_COUNT; i++) begin
        if (block_lock_in[i] && good_marker(lane_words_in[i]) && lane_words_in[i].bip_mismatch) begin
          bip_fault_out[lane_words_in[i].pcs_id] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Marker spacing and format faults
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      marker_spacing_fault_out <= `LANES_CLEAR;
      marker_format_fault_out  <= 1'b0;
    end else begin
      marker_format_fault_out <= 1'b0;
      for (int i = 0; i < `LANE_COUNT; i++) begin
        marker_spacing_fault_out[i] <= block_lock_in[i] &
          spacing_miss(lane_words_in[i], seen_q[i], word_cnt_q[i], marker_spacing_minus_one_in);
        if (lane_words_in[i].valid && lane_words_in[i].marker && lane_words_in[i].marker_bad) begin
          marker_format_fault_out <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Consecutive marker errors
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      repeat_cnt_q            <= '0;
      marker_repeat_fault_out <= `LANES_CLEAR;
    end else begin
      marker_repeat_fault_out <= `LANES_CLEAR;
      for (int i = 0; i < `LANE_COUNT; i++) begin
        if (!block_lock_in[i]) begin
          repeat_cnt_q[i] <= `REPEAT_ZERO;
        end else if (lane_words_in[i].valid && lane_words_in[i].marker) begin
          if (lane_words_in[i].marker_bad ||
              spacing_miss(lane_words_in[i], seen_q[i], word_cnt_q[i], marker_spacing_minus_one_in)) begin
            if (repeat_cnt_q[i] == `REPEAT_LIMIT) begin
              repeat_cnt_q[i]            <= `REPEAT_ZERO;
              marker_repeat_fault_out[i] <= 1'b1;
            end else begin
              repeat_cnt_q[i] <= repeat_cnt_q[i] + `REPEAT_ONE;
            end
          end else begin
            repeat_cnt_q[i] <= `REPEAT_ZERO;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Loopback select synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_meta_q              <= `LOOP_SEL_RESET;
      transceiver_loop_sel_out <= `LOOP_SEL_RESET;
    end else begin
      loop_meta_q              <= transceiver_loop_sel_in;
      transceiver_loop_sel_out <= loop_meta_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  lane_words_t words_prev_q;

  // Words of the previous cycle, for the mapping check
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      words_prev_q <= '0;
    end else begin
      words_prev_q <= lane_words_in;
    end
  end

  for (genvar g = 0; g < `LANE_COUNT; g++) begin : g_chk
    property p_lock_needs_marker;
      marker_lock_vec_out[g] |-> $past(block_lock_in[g]) && $past(seen_q[g]);
    endproperty
    a_lock_needs_marker: assert property (p_lock_needs_marker) else $error("lock bit without lock and marker");

    property p_lock_vs_fault;
      ##1 (marker_lock_vec_out[g] != sync_fault_out[g]);
    endproperty
    a_lock_vs_fault: assert property (p_lock_vs_fault) else $error("lock and sync fault disagree");

    property p_lost_lock_fault;
      !block_lock_in[g] |=> sync_fault_out[g] ##1 (sync_fault_out[g] || block_lock_in[g]);
    endproperty
    a_lost_lock_fault: assert property (p_lost_lock_fault) else $error("sync fault missing after lock loss");

    property p_spacing;
      (block_lock_in[g] && lane_words_in[g].valid && lane_words_in[g].marker && seen_q[g]
        && word_cnt_q[g] != marker_spacing_minus_one_in) |=> marker_spacing_fault_out[g];
    endproperty
    a_spacing: assert property (p_spacing) else $error("spacing fault not raised");

    property p_spacing_ok;
      (block_lock_in[g] && lane_words_in[g].valid && lane_words_in[g].marker
        && word_cnt_q[g] == marker_spacing_minus_one_in) |=> !marker_spacing_fault_out[g];
    endproperty
    a_spacing_ok: assert property (p_spacing_ok) else $error("spacing fault on correct spacing");

    property p_repeat;
      marker_repeat_fault_out[g] |-> $past(repeat_cnt_q[g]) == `REPEAT_LIMIT && repeat_cnt_q[g] == `REPEAT_ZERO;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat fault before fourth error");

    property p_format;
      (lane_words_in[g].valid && lane_words_in[g].marker && lane_words_in[g].marker_bad) |=> marker_format_fault_out;
    endproperty
    a_format: assert property (p_format) else $error("format fault missing");
  end

  property p_bip_pulse;
    (block_lock_in[0] && lane_words_in[0].valid && lane_words_in[0].marker && !lane_words_in[0].marker_bad
      && lane_words_in[0].bip_mismatch) |=> bip_fault_out[$past(lane_words_in[0].pcs_id)];
  endproperty
  a_bip_pulse: assert property (p_bip_pulse) else $error("bip fault missing");

  property p_map2;
    !$stable(lane2_phys_map_out) |-> words_prev_q[lane2_phys_map_out].valid
      && words_prev_q[lane2_phys_map_out].marker && !words_prev_q[lane2_phys_map_out].marker_bad
      && words_prev_q[lane2_phys_map_out].pcs_id == `PCS_LANE_2;
  endproperty
  a_map2: assert property (p_map2) else $error("lane 2 map changed without marker");

endmodule

`default_nettype wire

// File: sim/lane_feed.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Remote lanes as seen after the transceivers
// ----------------------------------------
module lane_feed
  import pcs_rx_lane_status_pkg::*;
(
  // Clock
  input  wire logic        clk_in,
  // Lane side
  output var  lane_words_t lane_words_out,
  output var  logic [3:0]  block_lock_out
);
  logic [1:0] idle_q = 2'h0;

  initial begin
    lane_words_out = '0;
    block_lock_out = 4'h0;
  end

  // Unused fields of idle words keep changing
  always @(posedge clk_in) begin
    idle_q <= idle_q + 2'h1;
  end

  // One word for one cycle, then idle
  task automatic put(input int lane, input logic mk, input logic bad, input lane_index_t id, input logic bip);
    @(posedge clk_in);
    lane_words_out[lane] <= '{1'b1, mk, bad, id, bip};
    @(posedge clk_in);
    lane_words_out[lane] <= '{1'b0, 1'b0, 1'b0, ~idle_q, idle_q[0]};
  endtask

  task automatic set_lock(input logic [3:0] v);
    @(posedge clk_in);
    block_lock_out <= v;
  endtask
endmodule

`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import pcs_rx_lane_status_pkg::*;
  typedef struct packed {int lane; lane_index_t id; logic [3:0] exp_bip; lane_index_t exp_map;} row_t;
  logic        clk_in, reset_in, fmt_f, fmt_s;
  lane_words_t lane_words;
  logic [3:0]  block_lock, bip_f, lock_v, sync_f, spc_f, rep_f, bip_s, spc_s, rep_s;
  spacing_t    spacing;
  logic [11:0] loop_sel, loop_out;
  lane_index_t map2, map3;
  int          error_cnt = 0;
  int          checks = 0;
  row_t        rows [4] = '{'{0, 2'h2, 4'h4, 2'h0}, '{1, 2'h3, 4'h8, 2'h1},
                            '{3, 2'h2, 4'h4, 2'h3}, '{2, 2'h3, 4'h8, 2'h2}};

  lane_feed lane_feed_inst (.clk_in(clk_in), .lane_words_out(lane_words), .block_lock_out(block_lock));

  pcs_rx_lane_status pcs_rx_lane_status_inst (
    .clk_in(clk_in), .reset_in(reset_in), .lane_words_in(lane_words), .block_lock_in(block_lock),
    .marker_spacing_minus_one_in(spacing), .transceiver_loop_sel_in(loop_sel),
    .lane2_phys_map_out(map2), .lane3_phys_map_out(map3), .bip_fault_out(bip_f),
    .marker_lock_vec_out(lock_v), .sync_fault_out(sync_f), .marker_spacing_fault_out(spc_f),
    .marker_repeat_fault_out(rep_f), .marker_format_fault_out(fmt_f), .transceiver_loop_sel_out(loop_out));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask

  // Send a word and capture the pulses of the following cycle
  task automatic word(input int lane, input logic mk, input logic bad, input lane_index_t id, input logic bip);
    lane_feed_inst.put(lane, mk, bad, id, bip);
    #1;
    {bip_s, spc_s, rep_s, fmt_s} = {bip_f, spc_f, rep_f, fmt_f};
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial begin
    reset_in = 1'b1;
    spacing  = 16'h0003;
    loop_sel = 12'h000;
    repeat (16) @(posedge clk_in);
    check("sync_rst", sync_f, 16'h000F);
    check("lock_rst", lock_v, 16'h0000);
    check("map_rst", {map2, map3}, 16'h0000);
    reset_in <= 1'b0;
    lane_feed_inst.set_lock(4'hF);
    @(posedge clk_in);
    loop_sel <= 12'hA5C;
    @(posedge clk_in);
    #1 check("loop_1", loop_out, 16'h0000);
    @(posedge clk_in);
    #1 check("loop_2", loop_out, 16'h0A5C);
    foreach (rows[i]) begin
      word(rows[i].lane, 1'b1, 1'b0, rows[i].id, 1'b1);
      check("bip", bip_s, rows[i].exp_bip);
      check("fmt_good", fmt_s, 16'h0000);
      repeat (2) @(posedge clk_in);
      #1 check("lock_bit", lock_v[rows[i].lane], 16'h0001);
      if (lock_v[rows[i].lane] === 1'b1) begin
        check("map", (rows[i].id == 2'h2) ? map2 : map3, rows[i].exp_map);
      end
    end
    check("lock_all", lock_v, 16'h000F);
    check("sync_none", sync_f, 16'h0000);
    repeat (3) word(0, 1'b0, 1'b0, 2'h0, 1'b0);
    word(0, 1'b1, 1'b0, 2'h2, 1'b0);
    check("spacing_ok", spc_s, 16'h0000);
    check("bip_clear", bip_s, 16'h0000);
    repeat (2) word(0, 1'b0, 1'b0, 2'h0, 1'b0);
    word(0, 1'b1, 1'b0, 2'h2, 1'b0);
    check("spacing_short", spc_s, 16'h0001);
    for (int n = 1; n <= 4; n++) begin
      word(2, 1'b1, 1'b1, 2'h2, 1'b1);
      check("format", fmt_s, 16'h0001);
      check("repeat", rep_s, (n == 4) ? 16'h0004 : 16'h0000);
    end
    check("map_kept", map2, 16'h0000);
    lane_feed_inst.set_lock(4'hD);
    repeat (3) @(posedge clk_in);
    #1 check("lock_drop", lock_v, 16'h000D);
    check("sync_drop", sync_f, 16'h0002);
    @(posedge clk_in);
    reset_in <= 1'b1;
    @(posedge clk_in);
    #1 check("sync_rst2", sync_f, 16'h000F);
    check("lock_rst2", lock_v, 16'h0000);
    check("map_rst2", {map2, map3}, 16'h0000);
    check("loop_rst2", loop_out, 16'h0000);
    @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 check("lock_rel2", lock_v, 16'h0000);
    check("sync_rel2", sync_f, 16'h000F);
    check("loop_rel2", loop_out, 16'h0A5C);
    finish_test();
  end
endmodule

`default_nettype wire
